/* lfs_pkg.sv */
// Constants, register map and encodings for the link fault block
package lfs_pkg;

    // Sequence ordered set codes
    localparam logic [7:0] SEQ_CODE = 8'h9c;
    localparam logic [7:0] LF_CODE = 8'h01;
    localparam logic [7:0] RF_CODE = 8'h02;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Bus geometry
    localparam int COLS = 2;
    localparam int COL_BITS = 32;
    localparam int COL_CTL = 4;
    localparam int DATA_W = 64;
    localparam int CTL_W = 8;

    // One local fault column and its control flags
    localparam logic [31:0] LF_COL = {LF_CODE, ZERO_BYTE, ZERO_BYTE, SEQ_CODE};
    localparam logic [3:0] SEQ_COL_CTL = 4'h1;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_LATCH = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0c;
    localparam logic [7:0] ADDR_IMASK = 8'h10;

    // Control register bits, write one to act
    localparam int CTRL_CLR_FAULT = 0;
    localparam int CTRL_CLR_LINK = 1;

    // Latch register bits
    localparam int LAT_FAULT = 0;
    localparam int LAT_LINK = 1;

    // Live status register bits
    localparam int ST_FAULT = 0;
    localparam int ST_LINK = 1;
    localparam int ST_RFAULT = 2;
    localparam int ST_SYNC = 3;
    localparam int ST_XLOCK = 4;
    localparam int ST_BLOCK = 5;
    localparam int ST_HIBER = 6;
    localparam int ST_EBUF = 7;

    // Interrupt event bits
    localparam int EV_W = 3;
    localparam int EV_FAULT = 0;
    localparam int EV_LINKDN = 1;
    localparam int EV_RFAULT = 2;

    // Elastic buffer fault stretch
    localparam int CLK_PERIOD_NS = 50;
    localparam int EBUF_HOLD_NS = 1000;
    localparam int EBUF_HOLD_CYC =
        (EBUF_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 5;
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(EBUF_HOLD_CYC);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 5'h00;
    localparam logic [HOLD_W-1:0] HOLD_ONE = 5'h01;

    // Latch reset values
    localparam logic LAT_FAULT_RST = 1'b1;
    localparam logic LAT_LINK_RST = 1'b0;

    // Receive sync state
    typedef enum logic [0:0] {
        SYNC_LOST = 1'b0,
        SYNC_OK = 1'b1
    } lfs_sync_e;

endpackage : lfs_pkg

/* lfs_col_match.sv */
// Recognises one sequence ordered set in a 32-bit column
`timescale 1ns/1ps
module lfs_col_match #(
    parameter logic [7:0] CODE = 8'h02
) (
    input wire logic [31:0] colData,
    input wire logic [3:0] colCtl,
    output logic hit
);

    // Lane 0 code with flag, zero lanes, lane 3 code
    always_comb begin
        hit = colCtl == lfs_pkg::SEQ_COL_CTL
            && colData[7:0] == lfs_pkg::SEQ_CODE
            && colData[23:8] == {lfs_pkg::ZERO_BYTE, lfs_pkg::ZERO_BYTE}
            && colData[31:24] == CODE;
    end

endmodule : lfs_col_match

/* lfs_latch.sv */
// Latching indicator that holds its active value until cleared
`timescale 1ns/1ps
module lfs_latch #(
    parameter logic ACTIVE = 1'b1,
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic live,
    input wire logic clear,
    output logic q
);

    // Single latched bit
    typedef struct packed {
        logic held;
    } lfs_latch_s;

    lfs_latch_s state;
    lfs_latch_s next_state;

    // Active value sticks; clear reloads the live value so set wins
    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.held = live;
        end else if (live == ACTIVE) begin
            next_state.held = ACTIVE;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state.held <= RST_VAL;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.held;

endmodule : lfs_latch

/* lfs_fault_core.sv */
// Receive-side local fault generation, status and register slave
`timescale 1ns/1ps
module lfs_fault_core (
    input wire logic clk,
    input wire logic rst_n,
    // Decoded receive stream from the line
    input wire logic [63:0] rxdIn,
    input wire logic [7:0] rxcIn,
    // Receive path health
    input wire logic xcvrLocked,
    input wire logic rxInReset,
    input wire logic signalPresent,
    input wire logic blockLock,
    input wire logic hiBer,
    input wire logic ebufOverflow,
    input wire logic ebufUnderflow,
    input wire logic pcsReset,
    input wire logic pmaReset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [31:0] rdData,
    // Stream toward the reconciliation layer
    output logic [63:0] rxdOut,
    output logic [7:0] rxcOut,
    // Status vector
    output logic localFault,
    output logic linkUp,
    output logic latchedFault,
    output logic latchedLinkUp,
    output logic remoteFault,
    output logic irq
);

    // Whole block state
    typedef struct packed {
        lfs_pkg::lfs_sync_e sync;
        logic [lfs_pkg::HOLD_W-1:0] holdCnt;
        logic [63:0] rxd;
        logic [7:0] rxc;
        logic localFault;
        logic linkUp;
        logic remoteFault;
        logic [lfs_pkg::EV_W-1:0] intStat;
        logic [lfs_pkg::EV_W-1:0] intMask;
        logic [31:0] rdData;
        logic irq;
    } lfs_core_s;

    lfs_core_s state;
    lfs_core_s next_state;

    // Remote fault hits per column
    logic [lfs_pkg::COLS-1:0] colRemote;
    // Register access decodes
    logic clrFault;
    logic clrLink;
    logic latchRead;
    logic anyReset;

    // Detect remote fault sets in each column
    genvar gi;
    generate
        for (gi = 0; gi < lfs_pkg::COLS; gi++) begin : g_col
            lfs_col_match #(
                .CODE(lfs_pkg::RF_CODE)
            ) u_match (
                .colData(rxdIn[gi*lfs_pkg::COL_BITS +: lfs_pkg::COL_BITS]),
                .colCtl(rxcIn[gi*lfs_pkg::COL_CTL +: lfs_pkg::COL_CTL]),
                .hit(colRemote[gi])
            );
        end
    endgenerate

    // Clear sources for both latches
    always_comb begin
        anyReset = pcsReset || pmaReset;
        latchRead = rdEn && addr == lfs_pkg::ADDR_LATCH;
        clrFault = anyReset || latchRead
            || (wrEn && addr == lfs_pkg::ADDR_CTRL
                && wrData[lfs_pkg::CTRL_CLR_FAULT]);
        clrLink = anyReset || latchRead
            || (wrEn && addr == lfs_pkg::ADDR_CTRL
                && wrData[lfs_pkg::CTRL_CLR_LINK]);
    end

    // Latched fault, held high
    lfs_latch #(
        .ACTIVE(1'b1),
        .RST_VAL(lfs_pkg::LAT_FAULT_RST)
    ) u_lat_fault (
        .clk(clk),
        .rst_n(rst_n),
        .live(state.localFault),
        .clear(clrFault),
        .q(latchedFault)
    );

    // Latched link status, held low
    lfs_latch #(
        .ACTIVE(1'b0),
        .RST_VAL(lfs_pkg::LAT_LINK_RST)
    ) u_lat_link (
        .clk(clk),
        .rst_n(rst_n),
        .live(state.linkUp),
        .clear(clrLink),
        .q(latchedLinkUp)
    );

    // Next state of the whole block
    always_comb begin
        logic ebufErr;
        logic ebufFault;
        logic faultNow;
        logic rfNow;
        logic [lfs_pkg::EV_W-1:0] events;
        ebufErr = ebufOverflow || ebufUnderflow;
        ebufFault = 1'b0;
        faultNow = 1'b0;
        rfNow = 1'b0;
        events = '0;
        next_state = state;

        // Sync machine parks in loss while no signal
        if (!signalPresent || !blockLock || anyReset) begin
            next_state.sync = lfs_pkg::SYNC_LOST;
        end else begin
            next_state.sync = lfs_pkg::SYNC_OK;
        end

        // Stretch a buffer slip so the MAC sees it
        if (ebufErr) begin
            next_state.holdCnt = lfs_pkg::HOLD_LOAD;
        end else if (state.holdCnt != lfs_pkg::HOLD_ZERO) begin
            next_state.holdCnt = state.holdCnt - lfs_pkg::HOLD_ONE;
        end
        ebufFault = ebufErr || state.holdCnt != lfs_pkg::HOLD_ZERO;

        // Receiver not up for any cause
        faultNow = !xcvrLocked || rxInReset || anyReset
            || !signalPresent || state.sync != lfs_pkg::SYNC_OK
            || !blockLock
            || hiBer
            || ebufFault;
        rfNow = |colRemote;

        // Replace the stream by local fault sets, else pass it through
        if (faultNow) begin
            next_state.rxd = {lfs_pkg::LF_COL, lfs_pkg::LF_COL};
            next_state.rxc = {lfs_pkg::SEQ_COL_CTL, lfs_pkg::SEQ_COL_CTL};
        end else begin
            next_state.rxd = rxdIn;
            next_state.rxc = rxcIn;
        end

        // Live status vector
        next_state.localFault = faultNow;
        next_state.linkUp = !faultNow;
        next_state.remoteFault = rfNow && !faultNow;

        // Interrupt events on rising fault, falling link and rising remote fault
        events[lfs_pkg::EV_FAULT] = faultNow && !state.localFault;
        events[lfs_pkg::EV_LINKDN] = faultNow && state.linkUp;
        events[lfs_pkg::EV_RFAULT] = next_state.remoteFault
            && !state.remoteFault;

        // Sticky status, read clears, a new event wins
        if (rdEn && addr == lfs_pkg::ADDR_ISTAT) begin
            next_state.intStat = events;
        end else begin
            next_state.intStat = state.intStat | events;
        end

        // Mask write
        if (wrEn && addr == lfs_pkg::ADDR_IMASK) begin
            next_state.intMask = wrData[lfs_pkg::EV_W-1:0];
        end
        next_state.irq = |(next_state.intStat & next_state.intMask);

        // Read data for one cycle only, unmapped reads give zero
        next_state.rdData = '0;
        if (rdEn) begin
            case (addr)
                lfs_pkg::ADDR_STAT: begin
                    next_state.rdData[lfs_pkg::ST_FAULT] = state.localFault;
                    next_state.rdData[lfs_pkg::ST_LINK] = state.linkUp;
                    next_state.rdData[lfs_pkg::ST_RFAULT] = state.remoteFault;
                    next_state.rdData[lfs_pkg::ST_SYNC] =
                        state.sync == lfs_pkg::SYNC_OK;
                    next_state.rdData[lfs_pkg::ST_XLOCK] = xcvrLocked;
                    next_state.rdData[lfs_pkg::ST_BLOCK] = blockLock;
                    next_state.rdData[lfs_pkg::ST_HIBER] = hiBer;
                    next_state.rdData[lfs_pkg::ST_EBUF] = ebufFault;
                end
                lfs_pkg::ADDR_LATCH: begin
                    next_state.rdData[lfs_pkg::LAT_FAULT] = latchedFault;
                    next_state.rdData[lfs_pkg::LAT_LINK] = latchedLinkUp;
                end
                lfs_pkg::ADDR_ISTAT: begin
                    next_state.rdData[lfs_pkg::EV_W-1:0] = state.intStat;
                end
                lfs_pkg::ADDR_IMASK: begin
                    next_state.rdData[lfs_pkg::EV_W-1:0] = state.intMask;
                end
                default: begin
                    next_state.rdData = '0;
                end
            endcase
        end
    end

    // State register, fault shown from reset onward
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state.sync <= lfs_pkg::SYNC_LOST;
            state.holdCnt <= lfs_pkg::HOLD_ZERO;
            state.rxd <= {lfs_pkg::LF_COL, lfs_pkg::LF_COL};
            state.rxc <= {lfs_pkg::SEQ_COL_CTL, lfs_pkg::SEQ_COL_CTL};
            state.localFault <= 1'b1;
            state.linkUp <= 1'b0;
            state.remoteFault <= 1'b0;
            state.intStat <= '0;
            state.intMask <= '0;
            state.rdData <= '0;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign rxdOut = state.rxd;
    assign rxcOut = state.rxc;
    assign localFault = state.localFault;
    assign linkUp = state.linkUp;
    assign remoteFault = state.remoteFault;
    assign irq = state.irq;
    assign rdData = state.rdData;

    // Checks on the outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    seq_lane_zero_a: assert property (
        localFault |-> rxdOut[7:0] == lfs_pkg::SEQ_CODE && rxcOut[0]
            && rxdOut[39:32] == lfs_pkg::SEQ_CODE && rxcOut[4])
        else $error("fault set does not start lane 0 with 0x9c");

    fault_set_body_a: assert property (
        localFault |-> rxdOut[31:8] == 24'h010000
            && rxcOut[3:1] == 3'h0 && rxcOut[7:5] == 3'h0)
        else $error("fault set lanes 1 to 3 wrong");

    not_ready_a: assert property (
        (!xcvrLocked || rxInReset) |=> localFault && !linkUp)
        else $error("no fault while transceiver not ready");

    block_lock_a: assert property (
        !blockLock |=> localFault)
        else $error("no fault without block lock");

    high_ber_a: assert property (
        hiBer |=> localFault)
        else $error("no fault under high error rate");

    ebuf_slip_a: assert property (
        (ebufOverflow || ebufUnderflow) |=> localFault [*8])
        else $error("buffer slip fault not held");

    no_signal_a: assert property (
        !signalPresent |=> state.sync == lfs_pkg::SYNC_LOST && localFault)
        else $error("sync left loss state without signal");

    pass_through_a: assert property (
        !localFault |-> rxdOut == $past(rxdIn) && rxcOut == $past(rxcIn))
        else $error("stream not passed through while up");

    fault_latches_a: assert property (
        localFault && !clrFault |=> latchedFault)
        else $error("live fault not latched");

    read_clears_a: assert property (
        latchRead && !localFault |=> !latchedFault
            && rdData[lfs_pkg::LAT_FAULT] == $past(latchedFault))
        else $error("latch read did not clear");

    status_read_a: assert property (
        rdEn && addr == lfs_pkg::ADDR_STAT |=>
            rdData[lfs_pkg::ST_FAULT] == $past(localFault))
        else $error("status read lost fault bit");

    fault_cleared_c: cover property (
        localFault ##1 !localFault ##1 !localFault);
    remote_seen_c: cover property (
        !localFault && remoteFault);
    irq_raised_c: cover property (
        !irq ##1 irq);
    link_relatched_c: cover property (
        !latchedLinkUp ##1 latchedLinkUp);

endmodule : lfs_fault_core

/* lfs_rs_model.sv */
// Reconciliation layer model at the far side of the receive stream
`timescale 1ns/1ps
module lfs_rs_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [63:0] rxd,
    input wire logic [7:0] rxc,
    input wire logic [63:0] txIn,
    input wire logic suppressRf,
    output logic [63:0] txd,
    output logic [7:0] txc
);
    // Idle characters in every lane
    localparam logic [63:0] IDLE_D = 64'h0707070707070707;
    // Remote fault column
    localparam logic [31:0] RF_COL =
        {lfs_pkg::RF_CODE, 16'h0000, lfs_pkg::SEQ_CODE};
    logic seenLf; // Local fault set in column 0
    logic seenRf; // Remote fault set in column 0
    assign seenLf = rxc[3:0] === 4'h1 && rxd[31:0] === lfs_pkg::LF_COL;
    assign seenRf = rxc[3:0] === 4'h1 && rxd[31:0] === RF_COL;
    // Transmit choice, registered like the real sublayer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd <= IDLE_D;
            txc <= 8'hff;
        end else if (seenLf && !suppressRf) begin
            // Answer a local fault with remote faults only
            txd <= {RF_COL, RF_COL};
            txc <= 8'h11;
        end else if (seenLf || seenRf) begin
            // Drop pending data, send idles
            txd <= IDLE_D;
            txc <= 8'hff;
        end else begin
            // Normal user data
            txd <= txIn;
            txc <= 8'h00;
        end
    end
endmodule : lfs_rs_model

/* link_fault_signalling_test.sv */
// Self-checking testbench for the link fault block
`timescale 1ns/1ps
module link_fault_signalling_test;
    logic clk, rst_n, xcvrLocked, rxInReset, signalPresent, blockLock;
    logic hiBer, ebufOverflow, ebufUnderflow, pcsReset, pmaReset;
    logic wrEn, rdEn, localFault, linkUp, latchedFault, latchedLinkUp;
    logic remoteFault, irq, suppressRf, randOn;
    logic [63:0] rxdIn, rxdOut, txd, prevD; // Streams
    logic [7:0] rxcIn, rxcOut, txc, addr; // Flags and address
    logic [31:0] wrData, rdData, rd; // Register data
    int err_total, n_tests, cyc, i;
    integer seed;
    // Expected fault words, both columns
    function automatic logic [63:0] lfWord();
        return {lfs_pkg::LF_COL, lfs_pkg::LF_COL};
    endfunction : lfWord
    function automatic logic [63:0] rfWord();
        return {2{lfs_pkg::RF_CODE, 16'h0000, lfs_pkg::SEQ_CODE}};
    endfunction : rfWord
    lfs_fault_core lfs_fault_core_inst (.clk(clk), .rst_n(rst_n),
        .rxdIn(rxdIn), .rxcIn(rxcIn), .xcvrLocked(xcvrLocked),
        .rxInReset(rxInReset), .signalPresent(signalPresent),
        .blockLock(blockLock), .hiBer(hiBer), .ebufOverflow(ebufOverflow),
        .ebufUnderflow(ebufUnderflow), .pcsReset(pcsReset),
        .pmaReset(pmaReset), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .rxdOut(rxdOut), .rxcOut(rxcOut),
        .localFault(localFault), .linkUp(linkUp),
        .latchedFault(latchedFault), .latchedLinkUp(latchedLinkUp),
        .remoteFault(remoteFault), .irq(irq));
    lfs_rs_model lfs_rs_model_inst (.clk(clk), .rst_n(rst_n),
        .rxd(rxdOut), .rxc(rxcOut), .txIn(prevD),
        .suppressRf(suppressRf), .txd(txd), .txc(txc));
    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Random line data, previous word and hang guard
    always @(posedge clk) begin
        if (randOn) rxdIn <= {$random(seed), $random(seed)};
        prevD <= rxdIn;
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    // Compare and count
    task automatic check(input string name, input logic [63:0] exp,
                         input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check
    // One-cycle register write
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin
            addr <= a;
            wrData <= d;
            wrEn <= 1'b1;
        end
        @(posedge clk) wrEn <= 1'b0;
    endtask : regWrite
    // Read, data taken in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) begin
            addr <= a;
            rdEn <= 1'b1;
        end
        @(posedge clk) rdEn <= 1'b0;
        #1 d = rdData;
    endtask : regRead
    // Raise or drop one fault cause
    task automatic setCause(input int k, input logic on);
        case (k)
            0: xcvrLocked <= !on;
            1: rxInReset <= on;
            2: signalPresent <= !on;
            3: blockLock <= !on;
            4: hiBer <= on;
            5: ebufOverflow <= on;
            6: ebufUnderflow <= on;
            7: pcsReset <= on;
            default: pmaReset <= on;
        endcase
        suppressRf <= on && k == 1;
    endtask : setCause
    // Counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        seed = 32'h934d;
        {rst_n, rxInReset, hiBer, ebufOverflow, ebufUnderflow} = 5'h00;
        {pcsReset, pmaReset, wrEn, rdEn, suppressRf, randOn} = 6'h00;
        {xcvrLocked, signalPresent, blockLock} = 3'h7;
        rxdIn = 64'h0;
        rxcIn = 8'h00;
        addr = 8'h00;
        wrData = 32'h0;
        repeat (10) @(posedge clk);
        #1;
        check("rxdOut", lfWord(), rxdOut);
        check("rxcOut", 64'h11, {56'h0, rxcOut});
        check("latched", 64'h1, {62'h0, latchedLinkUp, latchedFault});
        @(posedge clk) rst_n <= 1'b1;
        randOn <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("rxdOut", prevD, rxdOut);
        check("linkUp", 64'h1, {63'h0, linkUp});
        $display("test reset and pass-through done");
        // Interrupt on a fault, masked events, unmapped read
        regRead(lfs_pkg::ADDR_ISTAT, rd);
        regWrite(lfs_pkg::ADDR_IMASK, 32'h1);
        regRead(lfs_pkg::ADDR_IMASK, rd);
        check("imask", 64'h1, {61'h0, rd[2:0]});
        regRead(8'h20, rd);
        check("unmapped", 64'h0, {32'h0, rd});
        @(posedge clk) hiBer <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("irq", 64'h1, {63'h0, irq});
        @(posedge clk) hiBer <= 1'b0;
        repeat (5) @(posedge clk);
        regRead(lfs_pkg::ADDR_ISTAT, rd);
        check("istat", 64'h3, {61'h0, rd[2:0]});
        repeat (2) @(posedge clk);
        #1 check("irq", 64'h0, {63'h0, irq});
        regWrite(lfs_pkg::ADDR_IMASK, 32'h0);
        $display("test interrupt done");
        // Every fault cause, then both ways of clearing latches
        for (i = 0; i < 9; i++) begin
            @(posedge clk) setCause(i, 1'b1);
            repeat (3) @(posedge clk);
            #1;
            check("rxdOut", lfWord(), rxdOut);
            check("rxcOut", 64'h11, {56'h0, rxcOut});
            check("linkUp", 64'h0, {63'h0, linkUp});
            check("txd", (i == 1) ? 64'h0707070707070707 : rfWord(), txd);
            regRead(lfs_pkg::ADDR_STAT, rd);
            check("stat", 64'h1, {63'h0, rd[lfs_pkg::ST_FAULT]});
            @(posedge clk) setCause(i, 1'b0);
            repeat (30) @(posedge clk);
            #1;
            check("localFault", 64'h0, {63'h0, localFault});
            check("latchedFault", 64'h1, {63'h0, latchedFault});
            if (i % 2 == 0) begin
                regRead(lfs_pkg::ADDR_LATCH, rd);
                check("latch", 64'h1, {62'h0, rd[1:0]});
            end else begin
                regWrite(lfs_pkg::ADDR_CTRL, 32'h3);
            end
            regRead(lfs_pkg::ADDR_LATCH, rd);
            check("latch", 64'h2, {62'h0, rd[1:0]});
            $display("test cause %0d done", i);
        end
        // Remote fault from the line passes through
        @(posedge clk) randOn <= 1'b0;
        @(posedge clk) begin
            rxdIn <= rfWord();
            rxcIn <= 8'h11;
        end
        repeat (3) @(posedge clk);
        #1;
        check("rxdOut", rfWord(), rxdOut);
        check("remoteFault", 64'h1, {63'h0, remoteFault});
        check("localFault", 64'h0, {63'h0, localFault});
        check("txd", 64'h0707070707070707, txd);
        check("txc", 64'hff, {56'h0, txc});
        regRead(lfs_pkg::ADDR_ISTAT, rd);
        check("istat", 64'h1, {63'h0, rd[lfs_pkg::EV_RFAULT]});
        $display("test remote fault done");
        final_report();
    end
endmodule : link_fault_signalling_test
